/* rtl/tone_ctrl_device.sv */
// Device end: serial receiver and function control latches
//
// Overview of operation
// RULE1: Shift bits in while enable is low
// RULE2: Enable rise stops input, latches word
// RULE3: Eleven-bit frame, two address bits first
// RULE4: Three bits select the function
// RULE5: Last six bits carry the value
// RULE6: Power up flat tone, minimum levels
// RULE7: Volume has forty levels including mute
// RULE8: Two dB steps, twenty fader levels
// RULE9: Variant: four sources or three plus loudness
// RULE10: One bit per rising serial clock
// RULE11: Wrong address ignores frame entirely
// RULE12: Host holds clock low before enable falls
// RULE13: Extra bits allowed, last nine used
// RULE14: Only selected latch is updated
// RULE15: Short frame leaves latches unchanged
`timescale 1ns/1ps
module tone_ctrl_device
  import tone_ctrl_pkg::*;
#(
  parameter bit LOUDNESS_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  tone_link_if.device link,
  output logic [5:0] volume_level,
  output logic [5:0] bass_level,
  output logic [5:0] treble_level,
  output logic [5:0] fader_rf,
  output logic [5:0] fader_lf,
  output logic [5:0] fader_rr,
  output logic [5:0] fader_lr,
  output logic [1:0] source_sel,
  output logic loudness_on,
  output logic mute,
  output logic frame_taken
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } rx_state_type;

  // Whole state in one word: synchronisers, receiver and latches
  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdata_sync;
    logic [1:0] en_sync;
    logic sclk_prev;
    logic en_prev;
    rx_state_type state;
    logic [CNT_W-1:0] count;
    logic [1:0] addr;
    logic addr_ok;
    logic [PAYLOAD_BITS-1:0] shift;
    logic [5:0] volume;
    logic [5:0] bass;
    logic [5:0] treble;
    logic [5:0] f_rf;
    logic [5:0] f_lf;
    logic [5:0] f_rr;
    logic [5:0] f_lr;
    logic [5:0] input_ctl;
    logic taken;
  } dev_state_type;

  dev_state_type state_reg;
  dev_state_type state_next;

  logic sclk_s;
  logic en_s;
  logic sclk_rise;
  logic en_fall;
  logic en_rise;
  logic [2:0] func;
  logic [5:0] value;
  logic [5:0] vol_clamped;
  logic [5:0] fade_clamped;

  // Only the second synchroniser stage feeds logic
  assign sclk_s = state_reg.sclk_sync[1];
  assign en_s = state_reg.en_sync[1];
  assign sclk_rise = sclk_s & ~state_reg.sclk_prev;
  assign en_fall = ~en_s & state_reg.en_prev;
  assign en_rise = en_s & ~state_reg.en_prev;
  // RULE4 function select field
  assign func = state_reg.shift[PAYLOAD_BITS-1 -: FUNC_BITS];
  // RULE5 last six bits
  assign value = state_reg.shift[VALUE_BITS-1:0];

  // RULE7 forty volume levels
  assign vol_clamped = (value > VOLUME_MAX) ? VOLUME_MAX : value;
  // RULE8 twenty fader levels
  assign fade_clamped = (value > FADER_MAX) ? FADER_MAX : value;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.taken = 1'b0;
    state_next.sclk_sync = {state_reg.sclk_sync[0], link.sclk};
    state_next.sdata_sync = {state_reg.sdata_sync[0], link.sdata};
    state_next.en_sync = {state_reg.en_sync[0], link.enable_n};
    state_next.sclk_prev = sclk_s;
    state_next.en_prev = en_s;
    unique case (state_reg.state)
      ST_IDLE: begin
        // RULE1 frame opens on enable low
        if (en_fall) begin
          state_next.state = ST_ADDR;
          state_next.count = '0;
          state_next.addr = '0;
        end
      end
      ST_ADDR: begin
        if (en_rise) begin
          // RULE15 short frame discarded
          state_next.state = ST_IDLE;
        end else if (sclk_rise) begin
          // RULE3 address bits first
          state_next.addr = {state_reg.addr[0], state_reg.sdata_sync[1]};
          state_next.count = state_reg.count + 4'h1;
          if (state_reg.count + 4'h1 == ADDR_DONE) begin
            state_next.state = ST_DATA;
            // RULE11 address check
            state_next.addr_ok = ({state_reg.addr[0], state_reg.sdata_sync[1]} == DEVICE_ADDR);
          end
        end
      end
      ST_DATA: begin
        if (en_rise) begin
          // RULE2 latch on enable rise
          state_next.state = ST_IDLE;
          // RULE15 complete frame required
          if (state_reg.addr_ok && state_reg.count >= FRAME_LEN) begin
            state_next.taken = 1'b1;
            // RULE14 only selected latch
            unique case (func)
              FN_INPUT: state_next.input_ctl = value;
              FN_BASS: state_next.bass = value;
              FN_TREBLE: state_next.treble = value;
              FN_VOLUME: state_next.volume = vol_clamped;
              FN_FADE_RF: state_next.f_rf = fade_clamped;
              FN_FADE_LF: state_next.f_lf = fade_clamped;
              FN_FADE_RR: state_next.f_rr = fade_clamped;
              FN_FADE_LR: state_next.f_lr = fade_clamped;
            endcase
          end
        end else if (sclk_rise && state_reg.addr_ok) begin
          // RULE10 one bit per edge
          // RULE13 older bits fall off the end
          state_next.shift = {state_reg.shift[PAYLOAD_BITS-2:0], state_reg.sdata_sync[1]};
          // Count saturates, so a long frame still counts as full
          if (state_reg.count != FRAME_LEN) begin
            state_next.count = state_reg.count + 4'h1;
          end
        end
      end
      default: state_next.state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // RULE6 power-up values
      state_reg <= '{sclk_sync: 2'h0, sdata_sync: 2'h0, en_sync: 2'h3,
        sclk_prev: 1'b0, en_prev: 1'b1, state: ST_IDLE, count: 4'h0,
        addr: 2'h0, addr_ok: 1'b0, shift: 9'h000, volume: VOLUME_MIN,
        bass: TONE_FLAT, treble: TONE_FLAT, f_rf: FADER_MIN, f_lf: FADER_MIN,
        f_rr: FADER_MIN, f_lr: FADER_MIN, input_ctl: INPUT_RESET, taken: 1'b0};
    end else if (clk_en) begin
      // Everything, synchronisers included, holds while clk_en is low
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // RULE4 decoded control latches
  assign volume_level = state_reg.volume;
  assign bass_level = state_reg.bass;
  assign treble_level = state_reg.treble;
  assign fader_rf = state_reg.f_rf;
  assign fader_lf = state_reg.f_lf;
  assign fader_rr = state_reg.f_rr;
  assign fader_lr = state_reg.f_lr;
  // RULE9 variant trades one source for loudness
  // Code three has no input in the variant, so it parks on the last one
  assign source_sel = (LOUDNESS_VARIANT && state_reg.input_ctl[1:0] > SOURCE_LAST_LOUD)
                      ? SOURCE_LAST_LOUD : state_reg.input_ctl[1:0];
  assign loudness_on = LOUDNESS_VARIANT & state_reg.input_ctl[2];
  // Level zero of volume is the mute step
  assign mute = (state_reg.volume == VOLUME_MIN);
  assign frame_taken = state_reg.taken;

endmodule // tone_ctrl_device

/* rtl/tone_ctrl_host.sv */
// Host end: sends one eleven-bit frame per request over the link
`timescale 1ns/1ps
module tone_ctrl_host
  import tone_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire logic [1:0] req_addr,
  input wire logic [2:0] req_func,
  input wire logic [5:0] req_value,
  output logic req_ready,
  output logic done,
  tone_link_if.host link
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_SETUP = 4'b0010,
    H_SHIFT = 4'b0100,
    H_END = 4'b1000
  } host_state_type;

  typedef struct packed {
    host_state_type state;
    logic [FRAME_BITS-1:0] word;
    logic [CNT_W-1:0] bits;
    logic [4:0] div;
    logic sclk;
    logic sdata;
    logic enable_n;
    logic done;
  } host_reg_type;

  host_reg_type r_reg;
  host_reg_type r_next;
  logic half_done;

  assign half_done = (r_reg.div == SCLK_HALF - 5'h1);

  // Clock is a divided copy of clk, MSB first
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.div = half_done ? 5'h0 : r_reg.div + 5'h1;
    unique case (r_reg.state)
      H_IDLE: begin
        r_next.div = 5'h0;
        if (req_valid) begin
          r_next.word = {req_addr, req_func, req_value};
          r_next.bits = 4'h0;
          // RULE12 clock low before enable falls
          r_next.sclk = 1'b0;
          r_next.enable_n = 1'b0;
          r_next.sdata = req_addr[1];
          r_next.state = H_SETUP;
        end
      end
      H_SETUP: begin
        if (half_done) begin
          r_next.state = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (half_done) begin
          r_next.sclk = ~r_reg.sclk;
          if (r_reg.sclk) begin
            // Falling edge: next bit out, data settles before rise
            r_next.bits = r_reg.bits + 4'h1;
            r_next.word = {r_reg.word[FRAME_BITS-2:0], 1'b0};
            r_next.sdata = r_reg.word[FRAME_BITS-2];
            if (r_reg.bits + 4'h1 == FRAME_LEN) begin
              r_next.state = H_END;
              r_next.sdata = 1'b0;
            end
          end
        end
      end
      H_END: begin
        if (half_done) begin
          r_next.enable_n = 1'b1;
          r_next.done = 1'b1;
          r_next.state = H_IDLE;
        end
      end
      default: r_next.state = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r_reg <= '{state: H_IDLE, word: 11'h000, bits: 4'h0, div: 5'h0,
        sclk: 1'b0, sdata: 1'b0, enable_n: 1'b1, done: 1'b0};
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign req_ready = (r_reg.state == H_IDLE);
  assign done = r_reg.done;
  assign link.sclk = r_reg.sclk;
  assign link.sdata = r_reg.sdata;
  assign link.enable_n = r_reg.enable_n;

endmodule // tone_ctrl_host

/* rtl/tone_ctrl_pkg.sv */
// Shared constants for the three-wire tone and volume control link
package tone_ctrl_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int ADDR_BITS = 2;
  localparam int FUNC_BITS = 3;
  localparam int VALUE_BITS = 6;
  localparam int PAYLOAD_BITS = FUNC_BITS + VALUE_BITS;
  localparam int FRAME_BITS = ADDR_BITS + PAYLOAD_BITS;
  localparam logic [1:0] DEVICE_ADDR = 2'h2;
  localparam int CNT_W = 4;
  localparam logic [3:0] FRAME_LEN = 4'hb;
  localparam logic [3:0] ADDR_DONE = 4'h2;
  // ----------------------------------------
  // Function select codes
  // ----------------------------------------
  localparam logic [2:0] FN_INPUT = 3'h0;
  localparam logic [2:0] FN_BASS = 3'h1;
  localparam logic [2:0] FN_TREBLE = 3'h2;
  localparam logic [2:0] FN_VOLUME = 3'h3;
  localparam logic [2:0] FN_FADE_RF = 3'h4;
  localparam logic [2:0] FN_FADE_LF = 3'h5;
  localparam logic [2:0] FN_FADE_RR = 3'h6;
  localparam logic [2:0] FN_FADE_LR = 3'h7;
  // ----------------------------------------
  // Power-up values and level ranges
  // ----------------------------------------
  localparam logic [5:0] VOLUME_MIN = 6'h00;
  localparam logic [5:0] VOLUME_MAX = 6'h27;
  localparam logic [5:0] FADER_MIN = 6'h00;
  localparam logic [5:0] FADER_MAX = 6'h13;
  localparam logic [5:0] TONE_FLAT = 6'h06;
  localparam logic [5:0] INPUT_RESET = 6'h00;
  localparam logic [1:0] SOURCE_LAST_LOUD = 2'h2;
  localparam logic [3:0] STEP_DB = 4'h2;
  // ----------------------------------------
  // Link clock divider (host side)
  // ----------------------------------------
  localparam int SCLK_PERIOD_NS = 2000;
  localparam int CLK_PERIOD_NS = 100;
  localparam logic [4:0] SCLK_HALF = 5'(SCLK_PERIOD_NS / CLK_PERIOD_NS / 2);
endpackage

/* rtl/tone_link_if.sv */
// Three-wire control link between host controller and tone device
`timescale 1ns/1ps
interface tone_link_if;
  logic sclk;
  logic sdata;
  logic enable_n;
  modport host (output sclk, output sdata, output enable_n);
  modport device (input sclk, input sdata, input enable_n);
endinterface

/* tb/tb_top.sv */
// Bench: host and device joined, plus a second device fed by hand
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end
module tb_top
  import tone_ctrl_pkg::*;
;
  typedef struct {logic [2:0] func; logic [5:0] value; logic [5:0] want;} row_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_addr = 2'h0;
  logic [2:0] req_func = 3'h0;
  logic [5:0] req_value = 6'h00;
  logic req_ready, done, taken_a, taken_b, mute_a, loud_a, loud_b;
  logic [1:0] src_a, src_b;
  logic [5:0] vol_b;
  logic [5:0] lat_a [8];
  logic [5:0] exp_st [8];
  int n_fail = 0;
  int check_count = 0;
  // Ordinary frames; clamped values show up in the want column
  row_type rows [10] = '{
    '{FN_VOLUME, 6'h27, 6'h27}, '{FN_VOLUME, 6'h3f, 6'h27}, '{FN_BASS, 6'h0c, 6'h0c},
    '{FN_TREBLE, 6'h01, 6'h01}, '{FN_INPUT, 6'h03, 6'h03}, '{FN_FADE_RF, 6'h13, 6'h13},
    '{FN_FADE_LF, 6'h3f, 6'h13}, '{FN_FADE_RR, 6'h05, 6'h05}, '{FN_FADE_LR, 6'h00, 6'h00},
    '{FN_VOLUME, 6'h00, 6'h00}};
  tone_link_if link_a();
  tone_link_if link_b();
  tone_ctrl_host tone_ctrl_host_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .req_valid(req_valid), .req_addr(req_addr), .req_func(req_func), .req_value(req_value),
    .req_ready(req_ready), .done(done), .link(link_a.host));
  tone_ctrl_device tone_ctrl_device_i (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .link(link_a.device), .volume_level(lat_a[3]), .bass_level(lat_a[1]),
    .treble_level(lat_a[2]), .fader_rf(lat_a[4]), .fader_lf(lat_a[5]), .fader_rr(lat_a[6]),
    .fader_lr(lat_a[7]), .source_sel(src_a), .loudness_on(loud_a), .mute(mute_a),
    .frame_taken(taken_a));
  // Second end runs the loudness variant; its link is driven by the bench
  tone_ctrl_device #(.LOUDNESS_VARIANT(1'b1)) tone_ctrl_device_b_i (.clk(clk),
    .reset_n(reset_n), .clk_en(clk_en), .link(link_b.device), .volume_level(vol_b),
    .bass_level(), .treble_level(), .fader_rf(), .fader_lf(), .fader_rr(), .fader_lr(),
    .source_sel(src_b), .loudness_on(loud_b), .mute(), .frame_taken(taken_b));
  tone_link_props tone_link_props_i (.clk(clk), .reset_n(reset_n), .sclk(link_a.sclk),
    .sdata(link_a.sdata), .enable_n(link_a.enable_n));
  always #50 clk = ~clk;
  function automatic logic [5:0] seen(input int i);
    return (i == 0) ? {4'h0, src_a} : lat_a[i];
  endfunction
  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check_all();
    for (int i = 0; i < 8; i++) begin
      `CHK("latch", seen(i), exp_st[i])
    end
  endtask
  // Pulse is short, so every falling edge is looked at
  task automatic wait_take(input bit on_b, output bit hit);
    hit = 1'b0;
    for (int k = 0; k < 12; k++) begin
      @(negedge clk);
      if ((on_b ? taken_b : taken_a) === 1'b1) hit = 1'b1;
    end
  endtask
  task automatic send(input logic [1:0] a, input logic [2:0] f, input logic [5:0] v,
                      input bit want);
    int k;
    bit hit;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_func <= f;
    req_value <= v;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    `CHK("ready", req_ready, 1'b0)
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k == 400) begin
      n_fail++;
      stop_test();
    end
    wait_take(1'b0, hit);
    `CHK("taken", hit, want)
  endtask
  // Clock held low before enable falls; data line flipped once released
  // Each link clock phase is four system clocks, an 800 ns period
  task automatic raw_frame(input logic [15:0] bits, input int n, input bit want);
    bit hit;
    @(posedge clk);
    link_b.enable_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sdata <= bits[i];
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    link_b.enable_n <= 1'b1;
    link_b.sdata <= ~link_b.sdata;
    wait_take(1'b1, hit);
    `CHK("taken_b", hit, want)
  endtask
  initial begin
    link_b.sclk = 1'b0;
    link_b.sdata = 1'b0;
    link_b.enable_n = 1'b1;
    for (int i = 0; i < 8; i++) exp_st[i] = (i == 1 || i == 2) ? TONE_FLAT : 6'h00;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    `CHK("mute", mute_a, 1'b1)
    `CHK("ready", req_ready, 1'b1)
    check_all();
    foreach (rows[r]) begin
      send(DEVICE_ADDR, rows[r].func, rows[r].value, 1'b1);
      exp_st[rows[r].func] = rows[r].want;
      `CHK("value", seen(rows[r].func), rows[r].want)
      check_all();
    end
    `CHK("mute", mute_a, 1'b1)
    `CHK("loud_a", loud_a, 1'b0)
    send(2'h3, FN_VOLUME, 6'h10, 1'b0);
    check_all();
    // Hand-made frames on the second link; source code three parks on the last input
    raw_frame({5'h00, 2'b10, FN_INPUT, 6'h07}, 11, 1'b1);
    `CHK("source_b", src_b, SOURCE_LAST_LOUD)
    `CHK("loud_b", loud_b, 1'b1)
    raw_frame({3'h0, 2'b10, 2'b01, FN_VOLUME, 6'h15}, 13, 1'b1);
    `CHK("vol_b", vol_b, 6'h15)
    raw_frame({6'h00, 2'b10, FN_VOLUME, 5'h03}, 10, 1'b0);
    `CHK("vol_b", vol_b, 6'h15)
    // Clock enable low: a whole valid frame goes by unseen
    @(posedge clk);
    clk_en <= 1'b0;
    raw_frame({5'h00, 2'b10, FN_VOLUME, 6'h20}, 11, 1'b0);
    clk_en <= 1'b1;
    `CHK("vol_b", vol_b, 6'h15)
    // Second reset in mid-run restores power-up levels
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    for (int i = 0; i < 8; i++) exp_st[i] = (i == 1 || i == 2) ? TONE_FLAT : 6'h00;
    `CHK("vol_b", vol_b, VOLUME_MIN)
    check_all();
    stop_test();
  end
endmodule // tb_top

/* tb/tone_link_props.sv */
// Wire checks on the three-wire control link
`timescale 1ns/1ps
module tone_link_props (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic enable_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [4:0] rise_cnt_reg;
  // Rises of the serial clock in the open frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_cnt_reg <= 5'h00;
    end else if (enable_n) begin
      rise_cnt_reg <= 5'h00;
    end else if ($rose(sclk)) begin
      rise_cnt_reg <= rise_cnt_reg + 5'h01;
    end
  end
  start_clk_low_a: assert property ($fell(enable_n) |-> !sclk)
    else $error("Clock high as frame opened");
  first_half_low_a: assert property ($fell(enable_n) |-> !sclk [*8])
    else $error("Clock rose too soon");
  idle_clk_low_a: assert property (enable_n |-> !sclk)
    else $error("Clock moved outside a frame");
  frame_bits_a: assert property ($rose(enable_n) |-> rise_cnt_reg == 5'h0b)
    else $error("Frame not eleven bits");
  frame_span_a: assert property ($fell(enable_n) |-> ##[230:250] $rose(enable_n))
    else $error("Frame length off");
  data_setup_a: assert property ($rose(sclk) |-> $stable(sdata))
    else $error("Data moved at clock rise");
  data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("Data moved while clock high");
  clk_high_time_a: assert property ($rose(sclk) |-> sclk [*8])
    else $error("Clock high phase short");
  cover property ($rose(enable_n));
  cover property ($rose(sclk) && sdata);
  cover property (rise_cnt_reg == 5'h0b);
endmodule // tone_link_props
